// >>> src/lais_ctrl.sv
// Per-channel event capture and interrupt generation, AXI4-Lite slave.
// Assumes live status and event pulses come from logic on aclk.
//
// How it works
// - Each channel has both status registers, stride 0x40, channel 0 near top.
// - Both status registers reset to zero in every channel.
// - Writing one clears a status bit; writing zero leaves it.
// - Waveform overflow pulse sets status A bit 7, reported on irq.
// - Transmit jitter FIFO over/underflow sets status A bit 6.
// - Receive jitter FIFO over/underflow sets status A bit 5.
// - Overcurrent bit sets on rise, or any edge when select b4 set.
// - Clock-missing bit sets on rise, or any edge when select b3 set.
// - Transmit loss bit sets on rise, or any edge when select b2 set.
// - System and line loss bits share select b1 for edge choice.
// - System and line alarm-indication bits share select b6.
// - Pattern sync bit sets on rise, or any edge when select b5 set.
// - Activate and deactivate loop code bits share select b0.
// - Status B bits 4 to 2 are reserved and never set.
// - Each source has a mask bit, one blocks it; masks reset to one.
`timescale 1ns/1ps
`include "lais_consts.svh"

module lais_ctrl
(
   input  wire logic                                   aclk,
   input  wire logic                                   aresetn,
   input  wire logic [`LAIS_ADDR_W-1:0]                awaddr,
   input  wire logic                                   awvalid,
   output logic                                        awready,
   input  wire logic [31:0]                            wdata,
   input  wire logic [3:0]                             wstrb,
   input  wire logic                                   wvalid,
   output logic                                        wready,
   output logic [1:0]                                  bresp,
   output logic                                        bvalid,
   input  wire logic                                   bready,
   input  wire logic [`LAIS_ADDR_W-1:0]                araddr,
   input  wire logic                                   arvalid,
   output logic                                        arready,
   output logic [31:0]                                 rdata,
   output logic [1:0]                                  rresp,
   output logic                                        rvalid,
   input  wire logic                                   rready,
   input  wire lais_pkg::lais_live_t  [`LAIS_NCHAN-1:0] live,
   input  wire lais_pkg::lais_pulse_t [`LAIS_NCHAN-1:0] pulse,
   output logic                                        irq
);

   localparam int NCH = `LAIS_NCHAN;

   logic [`LAIS_ADDR_W-1:0] aw_addr;
   logic                    aw_full;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    w_full;
   logic                    wr_fire;
   lais_pkg::lais_dec_t     wr_dec;
   lais_pkg::lais_dec_t     rd_dec;
   logic [31:0]             wr_lanes;
   logic [7:0]              stat_a [0:NCH-1];
   logic [7:0]              stat_b [0:NCH-1];
   logic [7:0]              mask_a [0:NCH-1];
   logic [7:0]              mask_b [0:NCH-1];
   logic [7:0]              edge_sel [0:NCH-1];
   logic [7:0]              set_a [0:NCH-1];
   logic [7:0]              set_b [0:NCH-1];
   logic [NCH-1:0]          pending;
   logic [NCH-1:0]          enable;
   logic [NCH-1:0]          glob_clr;

   // Register index to channel and register; channel 0 sits in block 0x1f
   function automatic lais_pkg::lais_dec_t lais_decode
      (input logic [10:0] idx);
      lais_pkg::lais_dec_t d;
      logic [4:0]          blk;
      d.hit  = 1'b0;
      d.sel  = lais_pkg::REG_NONE;
      d.chan = 5'h00;
      blk    = idx[10:6];
      if (idx == `LAIS_IDX_SUMMARY)
         d.sel = lais_pkg::REG_SUMMARY;
      else if (idx == `LAIS_IDX_ENABLE)
         d.sel = lais_pkg::REG_ENABLE;
      else if (idx == `LAIS_IDX_CLEAR)
         d.sel = lais_pkg::REG_CLEAR;
      else if (blk == `LAIS_CH0_BLOCK || blk <= `LAIS_LAST_BLOCK)
      begin
         d.chan = (blk == `LAIS_CH0_BLOCK) ? 5'h00 : blk + 5'h01;
         case (idx[5:0])
            `LAIS_IDX_STAT_A: d.sel = lais_pkg::REG_STAT_A;
            `LAIS_IDX_STAT_B: d.sel = lais_pkg::REG_STAT_B;
            `LAIS_IDX_MASK_A: d.sel = lais_pkg::REG_MASK_A;
            `LAIS_IDX_MASK_B: d.sel = lais_pkg::REG_MASK_B;
            `LAIS_IDX_EDGE:   d.sel = lais_pkg::REG_EDGE;
            default:          d.sel = lais_pkg::REG_NONE;
         endcase
      end
      d.hit = (d.sel != lais_pkg::REG_NONE);
      return d;
   endfunction

   // Expand byte strobes to a bit mask
   function automatic logic [31:0] lais_lanes(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
      begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   // Write address and data are taken in either order, then executed
   assign wr_fire  = aw_full && w_full && !bvalid;
   assign wr_dec   = lais_decode(aw_addr[12:2]);
   assign rd_dec   = lais_decode(araddr[12:2]);
   assign wr_lanes = lais_lanes(w_strb);
   assign glob_clr = (wr_fire && wr_dec.sel == lais_pkg::REG_CLEAR)
                   ? NCH'(w_data & wr_lanes) : '0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full <= 1'b0;
         awready <= 1'b1;
         aw_addr <= '0;
      end
      else if (awvalid && awready)
      begin
         aw_full <= 1'b1;
         awready <= 1'b0;
         aw_addr <= awaddr;
      end
      else if (bvalid && bready)
      begin
         aw_full <= 1'b0;
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_full <= 1'b0;
         wready <= 1'b1;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end
      else if (wvalid && wready)
      begin
         w_full <= 1'b1;
         wready <= 1'b0;
         w_data <= wdata;
         w_strb <= wstrb;
      end
      else if (bvalid && bready)
      begin
         w_full <= 1'b0;
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= `LAIS_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid <= 1'b1;
         bresp  <= wr_dec.hit ? `LAIS_RESP_OKAY : `LAIS_RESP_DECERR;
      end
      else if (bready)
      begin
         bvalid <= 1'b0;
      end
   end

   // Global interrupt enable, one bit per channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         enable <= `LAIS_ENABLE_RST;
      else if (wr_fire && wr_dec.sel == lais_pkg::REG_ENABLE)
         enable <= NCH'((w_data & wr_lanes) | ({10'h000, enable} & ~wr_lanes));
   end

   genvar c;
   generate
      for (c = 0; c < NCH; c++)
      begin : g_chan
         logic [7:0] live_a;
         logic [7:0] live_b;
         logic [7:0] prev_a;
         logic [7:0] prev_b;
         logic [7:0] sel_a;
         logic [7:0] sel_b;
         logic [7:0] clr_a;
         logic [7:0] clr_b;
         logic       wr_ch;
         logic [7:0] es;

         assign es     = edge_sel[c];
         assign live_a = {3'h0, live[c].overcurrent_live,
                          live[c].clock_missing_live, live[c].tx_loss_live,
                          live[c].sys_loss_live, live[c].line_loss_live};
         assign live_b = {live[c].sys_alarm_ind_live,
                          live[c].line_alarm_ind_live,
                          live[c].pattern_sync_live, 3'h0,
                          live[c].loop_activate_live,
                          live[c].loop_deactivate_live};
         // Per-bit edge choice; shared select bits fan to both sources
         assign sel_a  = {3'h0, es[`LAIS_ES_OVC],
                          es[`LAIS_ES_CLKMISS],
                          es[`LAIS_ES_TXLOSS],
                          {2{es[`LAIS_ES_RXLOSS]}}};
         assign sel_b  = {{2{es[`LAIS_ES_ALARM]}},
                          es[`LAIS_ES_PATTERN], 3'h0,
                          {2{es[`LAIS_ES_LOOP]}}};
         assign set_a[c] = {pulse[c].wave_overflow_event,
                            pulse[c].tx_jitter_fifo_event,
                            pulse[c].rx_jitter_fifo_event, 5'h00}
                         | (live_a & ~prev_a)
                         | ((live_a ^ prev_a) & sel_a);
         assign set_b[c] = ((live_b & ~prev_b) | ((live_b ^ prev_b) & sel_b))
                         & `LAIS_STAT_B_USED;
         assign wr_ch  = wr_fire && wr_dec.hit && wr_dec.chan == 5'(c)
                      && w_strb[0];
         assign clr_a  = ((wr_ch && wr_dec.sel == lais_pkg::REG_STAT_A)
                       ? w_data[7:0] : 8'h00) | {8{glob_clr[c]}};
         assign clr_b  = ((wr_ch && wr_dec.sel == lais_pkg::REG_STAT_B)
                       ? w_data[7:0] : 8'h00) | {8{glob_clr[c]}};

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               prev_a <= 8'h00;
               prev_b <= 8'h00;
            end
            else
            begin
               prev_a <= live_a;
               prev_b <= live_b;
            end
         end

         // Sticky status: a set in the clearing cycle wins
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               stat_a[c] <= `LAIS_STAT_RST;
               stat_b[c] <= `LAIS_STAT_RST;
            end
            else
            begin
               stat_a[c] <= (stat_a[c] & ~clr_a) | set_a[c];
               stat_b[c] <= (stat_b[c] & ~clr_b) | set_b[c];
            end
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               mask_a[c]   <= `LAIS_MASK_A_RST;
               mask_b[c]   <= `LAIS_MASK_B_RST;
               edge_sel[c] <= `LAIS_EDGE_RST;
            end
            else if (wr_ch && wr_dec.sel == lais_pkg::REG_MASK_A)
               mask_a[c] <= w_data[7:0];
            else if (wr_ch && wr_dec.sel == lais_pkg::REG_MASK_B)
               mask_b[c] <= w_data[7:0] & `LAIS_STAT_B_USED;
            else if (wr_ch && wr_dec.sel == lais_pkg::REG_EDGE)
               edge_sel[c] <= w_data[7:0] & `LAIS_EDGE_USED;
         end

         assign pending[c] = |(stat_a[c] & ~mask_a[c])
                           | |(stat_b[c] & ~mask_b[c]);
      end
   endgenerate

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(pending & enable);
   end

   // Read channel: data one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `LAIS_RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= rd_dec.hit ? `LAIS_RESP_OKAY : `LAIS_RESP_DECERR;
         case (rd_dec.sel)
            lais_pkg::REG_STAT_A:  rdata <= {24'h0, stat_a[rd_dec.chan]};
            lais_pkg::REG_STAT_B:  rdata <= {24'h0, stat_b[rd_dec.chan]};
            lais_pkg::REG_MASK_A:  rdata <= {24'h0, mask_a[rd_dec.chan]};
            lais_pkg::REG_MASK_B:  rdata <= {24'h0, mask_b[rd_dec.chan]};
            lais_pkg::REG_EDGE:    rdata <= {24'h0, edge_sel[rd_dec.chan]};
            lais_pkg::REG_SUMMARY: rdata <= {10'h000, pending};
            lais_pkg::REG_ENABLE:  rdata <= {10'h000, enable};
            default:               rdata <= 32'h0000_0000;
         endcase
      end
      else if (rvalid && rready)
      begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
      end
   end

   // Checks on channel 1 (register block 0x00), plus write decode checks for channels 2 and 0
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_stat_reset_zero: assert property (
      $rose(aresetn) |-> stat_a[1] == 8'h00 && stat_b[1] == 8'h00)
      else $error("status not zero after reset");
   a_chan_decode: assert property (
      wr_fire && aw_addr[12:2] == 11'h060 |-> wr_dec.chan == 5'h02
      && wr_dec.sel == lais_pkg::REG_STAT_A)
      else $error("channel two status decode wrong");
   a_ch0_decode: assert property (
      wr_fire && aw_addr[12:2] == 11'h7e1 |-> wr_dec.chan == 5'h00
      && wr_dec.sel == lais_pkg::REG_STAT_B)
      else $error("channel zero status decode wrong");
   a_w1c_clear: assert property (
      wr_fire && wr_dec.sel == lais_pkg::REG_STAT_A && wr_dec.chan == 5'h01
      && w_strb[0] && w_data[0] && !set_a[1][0] |=> !stat_a[1][0])
      else $error("write one did not clear status bit");
   a_w0_keeps: assert property (
      stat_a[1][1] && !(wr_fire && w_data[1]) && !glob_clr[1]
      |=> stat_a[1][1])
      else $error("status bit lost without a clear");
   a_wave_set: assert property (
      pulse[1].wave_overflow_event |=> stat_a[1][7])
      else $error("waveform overflow not captured");
   a_txfifo_set: assert property (
      pulse[1].tx_jitter_fifo_event |=> stat_a[1][6])
      else $error("transmit fifo event not captured");
   a_rxfifo_set: assert property (
      pulse[1].rx_jitter_fifo_event |=> stat_a[1][5])
      else $error("receive fifo event not captured");
   a_ovc_edge: assert property (
      $past(edge_sel[1][4]) && $fell(live[1].overcurrent_live)
      |=> stat_a[1][4])
      else $error("overcurrent falling edge missed");
   a_clkmiss_rise: assert property (
      $rose(live[1].clock_missing_live) |=> stat_a[1][3])
      else $error("clock missing rise missed");
   a_txloss_level: assert property (
      !edge_sel[1][2] && !stat_a[1][2] && $stable(live[1].tx_loss_live)
      && !glob_clr[1] |=> !stat_a[1][2])
      else $error("transmit loss set without edge");
   a_rxloss_shared: assert property (
      edge_sel[1][1] && $fell(live[1].line_loss_live)
      |=> stat_a[1][0])
      else $error("shared loss select not applied");
   a_alarm_shared: assert property (
      !edge_sel[1][6] && !stat_b[1][7] && $fell(live[1].sys_alarm_ind_live)
      && !pulse[1].wave_overflow_event && !glob_clr[1] |=> !stat_b[1][7])
      else $error("alarm fall set with rise-only select");
   a_pattern_rise: assert property (
      $rose(live[1].pattern_sync_live) |=> stat_b[1][5])
      else $error("pattern sync rise missed");
   a_loop_shared: assert property (
      $past(edge_sel[1][0]) && $fell(live[1].loop_activate_live)
      |=> stat_b[1][1])
      else $error("loop code falling edge missed");
   a_resv_zero: assert property (
      stat_b[1][4:2] == 3'h0)
      else $error("reserved status bits set");
   a_mask_reset: assert property (
      $rose(aresetn) |-> mask_a[1] == 8'hff && mask_b[1] == 8'he3)
      else $error("masks not set after reset");
   a_irq_follow: assert property (
      stat_a[1][7] && !mask_a[1][7] && enable[1] |=> irq)
      else $error("unmasked status did not raise irq");

endmodule

// >>> include/lais_consts.svh
// Constants for the per-channel line alarm interrupt status block.
// Assumes word-indexed registers: byte address is four times the index.
`ifndef LAIS_CONSTS_SVH
`define LAIS_CONSTS_SVH

`define LAIS_NCHAN         22
`define LAIS_ADDR_W        13
// Register index layout: block = idx[10:6], offset = idx[5:0]
`define LAIS_CHAN_STRIDE   11'h040
`define LAIS_CH0_BLOCK     5'h1f
`define LAIS_LAST_BLOCK    5'h14
`define LAIS_IDX_STAT_A    6'h20
`define LAIS_IDX_STAT_B    6'h21
`define LAIS_IDX_EDGE      6'h19
`define LAIS_IDX_MASK_A    6'h1a
`define LAIS_IDX_MASK_B    6'h1b
`define LAIS_IDX_SUMMARY   11'h7f0
`define LAIS_IDX_ENABLE    11'h7f1
`define LAIS_IDX_CLEAR     11'h7f2
// Reset values
`define LAIS_STAT_RST      8'h00
`define LAIS_MASK_A_RST    8'hff
`define LAIS_MASK_B_RST    8'he3
`define LAIS_EDGE_RST      8'h00
`define LAIS_ENABLE_RST    22'h3fffff
// Implemented bits
`define LAIS_STAT_B_USED   8'he3
`define LAIS_EDGE_USED     8'h7f
// Edge-select bit positions
`define LAIS_ES_LOOP       0
`define LAIS_ES_RXLOSS     1
`define LAIS_ES_TXLOSS     2
`define LAIS_ES_CLKMISS    3
`define LAIS_ES_OVC        4
`define LAIS_ES_PATTERN    5
`define LAIS_ES_ALARM      6
// AXI responses
`define LAIS_RESP_OKAY     2'h0
`define LAIS_RESP_DECERR   2'h3

`endif

// >>> include/lais_pkg.sv
// Types for the per-channel line alarm interrupt status block.
// Assumes lais_consts.svh supplies the numeric constants.
package lais_pkg;

   typedef struct packed {
      logic sys_alarm_ind_live;
      logic line_alarm_ind_live;
      logic pattern_sync_live;
      logic loop_activate_live;
      logic loop_deactivate_live;
      logic overcurrent_live;
      logic clock_missing_live;
      logic tx_loss_live;
      logic sys_loss_live;
      logic line_loss_live;
   } lais_live_t;

   typedef struct packed {
      logic wave_overflow_event;
      logic tx_jitter_fifo_event;
      logic rx_jitter_fifo_event;
   } lais_pulse_t;

   typedef enum logic [3:0] {
      REG_NONE,
      REG_STAT_A,
      REG_STAT_B,
      REG_MASK_A,
      REG_MASK_B,
      REG_EDGE,
      REG_SUMMARY,
      REG_ENABLE,
      REG_CLEAR
   } lais_reg_t;

   typedef struct packed {
      logic       hit;
      lais_reg_t  sel;
      logic [4:0] chan;
   } lais_dec_t;

endpackage

// >>> tb/lais_tb_top.sv
// Self-checking bench for the line alarm interrupt status block.
// Assumes lais_ctrl, lais_pkg and lais_consts.svh; the bench is the bus master.
`timescale 1ns/1ps
`include "lais_consts.svh"

module line_alarm_interrupt_status_tb_top;
   logic                                aclk;
   logic                                aresetn;
   logic [`LAIS_ADDR_W-1:0]             awaddr;
   logic                                awvalid;
   logic                                awready;
   logic [31:0]                         wdata;
   logic [3:0]                          wstrb;
   logic                                wvalid;
   logic                                wready;
   logic [1:0]                          bresp;
   logic                                bvalid;
   logic                                bready;
   logic [`LAIS_ADDR_W-1:0]             araddr;
   logic                                arvalid;
   logic                                arready;
   logic [31:0]                         rdata;
   logic [1:0]                          rresp;
   logic                                rvalid;
   logic                                rready;
   lais_pkg::lais_live_t  [`LAIS_NCHAN-1:0] live;
   lais_pkg::lais_pulse_t [`LAIS_NCHAN-1:0] pulse;
   logic                                irq;
   int                                  n_errors;
   int                                  n_checks;
   int                                  cycles;

   // Status bit and edge-select bit of each live source, struct bit order
   localparam int ST_BIT  [10] = '{0, 1, 2, 3, 4, 0, 1, 5, 6, 7};
   localparam int SEL_BIT [10] = '{1, 1, 2, 3, 4, 0, 0, 5, 6, 6};
   localparam int LIMIT        = 20000;

   lais_ctrl lais_ctrl_inst
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .live    (live),
      .pulse   (pulse),
      .irq     (irq)
   );

   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         n_errors++;
         $display("Error at %0t: bench timeout", $time);
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string msg);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: %s seen %h expected %h", $time, msg,
                  seen, exp);
      end
   endtask

   // Byte address of a channel register; channel 0 sits near the top
   function automatic logic [12:0] ba(input int ch, input logic [5:0] off);
      logic [10:0] idx;
      idx = (ch == 0) ? 11'h7c0 + 11'(off) : 11'((ch - 1) * 64) + 11'(off);
      return {idx, 2'b00};
   endfunction

   task automatic wr_r(input logic [12:0] a, input logic [31:0] d,
                       output logic [1:0] r);
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hf;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1)
            awvalid <= 1'b0;
         if (wvalid && wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
            break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd_r(input logic [12:0] a, output logic [31:0] d,
                       output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever
      begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
            break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr_r(a, d, r);
      chk(32'(r), 32'(`LAIS_RESP_OKAY), "write response");
   endtask

   task automatic rd_chk(input logic [12:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd_r(a, d, r);
      chk(32'(r), 32'(`LAIS_RESP_OKAY), "read response");
      chk(d, exp, "read data");
   endtask

   task automatic t_reset();
      rd_chk(ba(0, 6'h20), 32'h00);
      rd_chk(ba(0, 6'h21), 32'h00);
      rd_chk(ba(1, 6'h20), 32'h00);
      rd_chk(ba(21, 6'h21), 32'h00);
      rd_chk(ba(1, 6'h1a), 32'hff);
      rd_chk(ba(21, 6'h1b), 32'he3);
      chk(32'(irq), 32'h0, "irq after reset");
      $display("Test reset values done");
   endtask

   task automatic t_pulses();
      logic [7:0] acc;
      acc = 8'h00;
      for (int b = 0; b < 3; b++)
      begin
         @(posedge aclk);
         pulse[1][b] <= 1'b1;
         @(posedge aclk);
         pulse[1][b] <= 1'b0;
         acc = acc | (8'h20 << b);
         rd_chk(ba(1, 6'h20), 32'(acc));
      end
      chk(32'(irq), 32'h0, "irq while masked");
      wr(ba(1, 6'h1a), 32'h00);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h1, "irq unmasked");
      wr(ba(1, 6'h20), 32'h80);
      rd_chk(ba(1, 6'h20), 32'h60);
      wr(ba(1, 6'h20), 32'h00);
      rd_chk(ba(1, 6'h20), 32'h60);
      wr(ba(1, 6'h20), 32'h60);
      rd_chk(ba(1, 6'h20), 32'h00);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h0, "irq after clear");
      $display("Test event pulses done");
   endtask

   task automatic set_live(input int s, input logic v);
      @(posedge aclk);
      live[1][s] <= v;
      repeat (2) @(posedge aclk);
   endtask

   task automatic t_edges();
      logic [12:0] sa;
      logic [7:0]  m;
      for (int s = 0; s < 10; s++)
      begin
         sa = ba(1, (s < 5) ? 6'h20 : 6'h21);
         m = 8'h01 << ST_BIT[s];
         wr(ba(1, 6'h19), 32'h00);
         set_live(s, 1'b1);
         rd_chk(sa, 32'(m));
         wr(sa, 32'(m));
         rd_chk(sa, 32'h00);
         set_live(s, 1'b0);
         rd_chk(sa, 32'h00);
         wr(ba(1, 6'h19), 32'h01 << SEL_BIT[s]);
         set_live(s, 1'b1);
         wr(sa, 32'(m));
         set_live(s, 1'b0);
         rd_chk(sa, 32'(m));
         rd_chk(ba(0, (s < 5) ? 6'h20 : 6'h21), 32'h00);
         wr(sa, 32'(m));
      end
      rd_chk(ba(1, 6'h19), 32'h40);
      rd_chk(ba(0, 6'h20), 32'h00);
      rd_chk(ba(0, 6'h21), 32'h00);
      wr(ba(0, 6'h21), 32'hff);
      rd_chk(ba(0, 6'h21), 32'h00);
      wr(ba(2, 6'h20), 32'hff);
      rd_chk(ba(2, 6'h20), 32'h00);
      $display("Test edge selection done");
   endtask

   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0]  r;
      rd_r(13'h1800, d, r);
      chk(32'(r), 32'(`LAIS_RESP_DECERR), "unmapped read response");
      chk(d, 32'h0, "unmapped read data");
      wr_r(13'h1800, 32'hff, r);
      chk(32'(r), 32'(`LAIS_RESP_DECERR), "unmapped write response");
      $display("Test unmapped access done");
   endtask

   task automatic t_global();
      @(posedge aclk);
      pulse[1][2] <= 1'b1;
      @(posedge aclk);
      pulse[1][2] <= 1'b0;
      rd_chk({`LAIS_IDX_SUMMARY, 2'b00}, 32'h02);
      wr({`LAIS_IDX_ENABLE, 2'b00}, 32'h3ffffd);
      rd_chk({`LAIS_IDX_ENABLE, 2'b00}, 32'h3ffffd);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h0, "irq channel disabled");
      wr({`LAIS_IDX_ENABLE, 2'b00}, 32'h3fffff);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h1, "irq channel enabled");
      wr({`LAIS_IDX_CLEAR, 2'b00}, 32'h02);
      rd_chk(ba(1, 6'h20), 32'h00);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h0, "irq after global clear");
      wr(ba(1, 6'h1b), 32'hff);
      rd_chk(ba(1, 6'h1b), 32'he3);
      $display("Test global registers done");
   endtask

   task automatic t_midreset();
      @(posedge aclk);
      pulse[1][1] <= 1'b1;
      @(posedge aclk);
      pulse[1][1] <= 1'b0;
      aresetn     <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(ba(1, 6'h20), 32'h00);
      rd_chk(ba(1, 6'h1a), 32'hff);
      rd_chk(ba(1, 6'h1b), 32'he3);
      chk(32'(irq), 32'h0, "irq after mid-run reset");
      $display("Test mid-run reset done");
   endtask

   initial
   begin
      n_errors = 0;
      n_checks = 0;
      cycles   = 0;
      aresetn <= 1'b0;
      awaddr  <= '0;
      awvalid <= 1'b0;
      wdata   <= '0;
      wstrb   <= 4'h0;
      wvalid  <= 1'b0;
      bready  <= 1'b0;
      araddr  <= '0;
      arvalid <= 1'b0;
      rready  <= 1'b0;
      live    <= '0;
      pulse   <= '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_pulses();
      t_edges();
      t_global();
      t_midreset();
      t_unmapped();
      stop_test();
   end
endmodule
